// ==== design/uart_link_pkg.sv ====
// Shared constants for the serial port end and its partner end
package uart_link_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int BAUD_RATE = 115200;
    // Longest whole bit time that fits the rate; rounds down
    localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
    localparam int DATA_BITS = 8;
    localparam int FIFO_DEPTH = 8;
    // Time the data strap is pulled low before the clock strap is read
    localparam int STRAP_SETTLE_NS = 1000;
    localparam int STRAP_CYCLES = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic LINE_IDLE = 1'b1;
    localparam logic START_LEVEL = 1'b0;
    localparam logic STOP_LEVEL = 1'b1;
    localparam logic STRAP_DRIVE_LEVEL = 1'b0;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_DATA = 2'b11,
        TX_STOP = 2'b10
    } tx_state_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b11,
        RX_STOP = 2'b10
    } rx_state_t;
    typedef enum logic [1:0] {
        STRAP_DRIVE = 2'b00,
        STRAP_SAMPLE = 2'b01,
        STRAP_DONE = 2'b11
    } strap_state_t;
endpackage : uart_link_pkg

// ==== design/uart_link_if.sv ====
// Serial link wires between the port end and its partner end
`timescale 1ns/1ns
interface uart_link_if;
    logic serial_out;          // Port end to partner data
    logic serial_in;           // Partner to port end data
    logic transmit_permit_n;   // Partner allows port end to send, low active
    logic ready_n;             // Port end can accept data, low active
    logic transmit_active;     // Port end is sending a byte
    logic receive_overflow_n;  // Port end receive buffer near or past overflow
    modport port_end (
        output serial_out,
        input serial_in,
        input transmit_permit_n,
        output ready_n,
        output transmit_active,
        output receive_overflow_n
    );
    modport partner_end (
        input serial_out,
        output serial_in,
        output transmit_permit_n,
        input ready_n,
        input transmit_active,
        input receive_overflow_n
    );
endinterface : uart_link_if

// ==== design/serial_port_end.sv ====
// Serial port end: strap decode, flow control and receive FIFO
`timescale 1ns/1ns

module byte_fifo #(
    parameter int WIDTH = uart_link_pkg::DATA_BITS,
    parameter int DEPTH = uart_link_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,                  // Clock
    input wire logic rst,                       // Synchronous reset
    input wire logic [WIDTH-1:0] in_data,       // Write data
    input wire logic in_valid,                  // Write request
    output logic in_ready,                      // Space available
    output logic [WIDTH-1:0] out_data,          // Head entry
    output logic out_valid,                     // Entry available
    input wire logic out_ready,                 // Consumer takes head
    output logic [$clog2(DEPTH+1)-1:0] count    // Entries held
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    logic [CW-1:0] count_ff;
    logic push;
    logic pop;

    assign in_ready = count_ff != FULL_COUNT;
    assign out_valid = count_ff != '0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_ff[rd_ptr_ff];
    assign count = count_ff;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + PW'(1);
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + PW'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            count_ff <= '0;
        end else if (push && !pop) begin
            count_ff <= count_ff + CW'(1);
        end else if (pop && !push) begin
            count_ff <= count_ff - CW'(1);
        end
    end
endmodule : byte_fifo

module serial_port_end #(
    parameter int BIT_CYCLES = uart_link_pkg::BIT_CYCLES,
    parameter int DEPTH = uart_link_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,                                // Clock, 20 MHz
    input wire logic rst,                                     // Synchronous reset, high
    input wire logic usb_configured,                          // Upstream side configured
    input wire logic [uart_link_pkg::DATA_BITS-1:0] tx_data,  // Byte to send
    input wire logic tx_valid,                                // Byte offered
    output logic tx_ready,                                    // Byte taken
    output logic [uart_link_pkg::DATA_BITS-1:0] rx_data,      // Received byte at FIFO head
    output logic rx_valid,                                    // FIFO not empty
    input wire logic rx_ready,                                // Consumer takes head
    input wire logic cfg_sda_in,                              // Data strap pin level
    output logic cfg_sda_out,                                 // Data strap drive level
    output logic cfg_sda_oe,                                  // Data strap driven
    input wire logic cfg_scl_in,                              // Clock strap pin level
    output logic serial_mode,                                 // Serial port selected
    output logic printer_mode,                                // Printer port selected
    uart_link_if.port_end link                                // Serial link
);
    localparam int SW = $clog2(uart_link_pkg::STRAP_CYCLES + 1);
    localparam logic [SW-1:0] STRAP_LAST = SW'(uart_link_pkg::STRAP_CYCLES - 1);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] NEAR_FULL = CW'(DEPTH - 1);
    uart_link_pkg::strap_state_t strap_ff;
    logic [SW-1:0] strap_cnt_ff;
    logic serial_mode_ff;
    logic printer_mode_ff;
    logic sda_oe_ff;
    logic [1:0] scl_sync_ff;
    logic [1:0] rxd_sync_ff;
    logic [1:0] permit_sync_ff;
    logic ready_n_ff;
    logic overflow_n_ff;
    logic dropped_ff;
    logic running;
    logic [uart_link_pkg::DATA_BITS-1:0] rx_byte;
    logic rx_byte_valid;
    logic fifo_in_ready;
    logic [CW-1:0] fifo_count;
    logic txd;

    always_ff @(posedge core_clk) begin
        scl_sync_ff <= {scl_sync_ff[0], cfg_scl_in};
        rxd_sync_ff <= {rxd_sync_ff[0], link.serial_in};
        permit_sync_ff <= {permit_sync_ff[0], link.transmit_permit_n};
    end

    // Pull the data strap low; a tied clock strap follows it low
    always_ff @(posedge core_clk) begin
        if (rst) begin
            strap_ff <= uart_link_pkg::STRAP_DRIVE;
            strap_cnt_ff <= '0;
            sda_oe_ff <= 1'b1;
            serial_mode_ff <= 1'b0;
            printer_mode_ff <= 1'b0;
        end else begin
            unique case (strap_ff)
                uart_link_pkg::STRAP_DRIVE: begin
                    strap_cnt_ff <= strap_cnt_ff + SW'(1);
                    if (strap_cnt_ff == STRAP_LAST) begin
                        strap_ff <= uart_link_pkg::STRAP_SAMPLE;
                    end
                end
                uart_link_pkg::STRAP_SAMPLE: begin
                    serial_mode_ff <= scl_sync_ff[1];
                    printer_mode_ff <= !scl_sync_ff[1];
                    sda_oe_ff <= 1'b0;
                    strap_ff <= uart_link_pkg::STRAP_DONE;
                end
                uart_link_pkg::STRAP_DONE: begin
                end
            endcase
        end
    end

    assign cfg_sda_out = uart_link_pkg::STRAP_DRIVE_LEVEL;
    assign cfg_sda_oe = sda_oe_ff;
    assign serial_mode = serial_mode_ff;
    assign printer_mode = printer_mode_ff;
    assign running = serial_mode_ff;

    // Optional modem lines are not needed; only data and permit pins steer transfers
    uart_bit_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
        .core_clk(core_clk),
        .rst(rst),
        .enable(running),
        .permit_n(permit_sync_ff[1]),
        .data(tx_data),
        .valid(tx_valid),
        .ready(tx_ready),
        .txd(txd),
        .active(link.transmit_active)
    );
    assign link.serial_out = txd;

    uart_bit_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
        .core_clk(core_clk),
        .rst(rst),
        .enable(running),
        .rxd(rxd_sync_ff[1]),
        .data(rx_byte),
        .valid(rx_byte_valid),
        .busy()
    );

    byte_fifo #(.WIDTH(uart_link_pkg::DATA_BITS), .DEPTH(DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_data(rx_byte),
        .in_valid(rx_byte_valid),
        .in_ready(fifo_in_ready),
        .out_data(rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .count(fifo_count)
    );

    // Not ready one entry early so a byte already on the wire still fits
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ready_n_ff <= 1'b1;
        end else begin
            ready_n_ff <= !(running && usb_configured && fifo_count < NEAR_FULL);
        end
    end
    assign link.ready_n = ready_n_ff;

    // Loss stays flagged until the buffer drains; a new loss wins over that clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dropped_ff <= 1'b0;
        end else if (rx_byte_valid && !fifo_in_ready) begin
            dropped_ff <= 1'b1;
        end else if (fifo_count == '0) begin
            dropped_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            overflow_n_ff <= 1'b1;
        end else begin
            overflow_n_ff <= !(fifo_count >= NEAR_FULL || dropped_ff || (rx_byte_valid && !fifo_in_ready));
        end
    end
    assign link.receive_overflow_n = overflow_n_ff;
endmodule : serial_port_end

// ==== design/serial_partner_end.sv ====
// Partner end with permit flow control, and the bit transmitter and receiver both ends use
`timescale 1ns/1ns
module serial_partner_end #(
    parameter int BIT_CYCLES = uart_link_pkg::BIT_CYCLES
) (
    input wire logic core_clk,                                // Clock, 20 MHz
    input wire logic rst,                                     // Synchronous reset, high
    input wire logic [uart_link_pkg::DATA_BITS-1:0] tx_data,  // Byte to send
    input wire logic tx_valid,                                // Byte offered
    output logic tx_ready,                                    // Byte taken
    output logic [uart_link_pkg::DATA_BITS-1:0] rx_data,      // Held received byte
    output logic rx_valid,                                    // Byte held
    input wire logic rx_ready,                                // Consumer takes byte
    output logic peer_active,                                 // Port end sending
    output logic peer_overflow,                               // Port end reports overflow
    uart_link_if.partner_end link                             // Serial link
);
    logic [1:0] txd_sync_ff;
    logic [1:0] ready_sync_ff;
    logic [1:0] active_sync_ff;
    logic [1:0] ovf_sync_ff;
    logic [uart_link_pkg::DATA_BITS-1:0] hold_ff;
    logic hold_valid_ff;
    logic permit_n_ff;
    logic peer_active_ff;
    logic peer_overflow_ff;
    logic [uart_link_pkg::DATA_BITS-1:0] rx_byte;
    logic rx_byte_valid;
    logic rx_busy;
    logic txd;

    always_ff @(posedge core_clk) begin
        txd_sync_ff <= {txd_sync_ff[0], link.serial_out};
        ready_sync_ff <= {ready_sync_ff[0], link.ready_n};
        active_sync_ff <= {active_sync_ff[0], link.transmit_active};
        ovf_sync_ff <= {ovf_sync_ff[0], link.receive_overflow_n};
    end

    // Port end's ready acts as our permit
    uart_bit_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
        .core_clk(core_clk),
        .rst(rst),
        .enable(1'b1),
        .permit_n(ready_sync_ff[1]),
        .data(tx_data),
        .valid(tx_valid),
        .ready(tx_ready),
        .txd(txd),
        .active()
    );
    assign link.serial_in = txd;

    uart_bit_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
        .core_clk(core_clk),
        .rst(rst),
        .enable(1'b1),
        .rxd(txd_sync_ff[1]),
        .data(rx_byte),
        .valid(rx_byte_valid),
        .busy(rx_busy)
    );

    // A new byte wins over the consumer's take in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hold_valid_ff <= 1'b0;
            hold_ff <= '0;
        end else if (rx_byte_valid) begin
            hold_valid_ff <= 1'b1;
            hold_ff <= rx_byte;
        end else if (rx_ready) begin
            hold_valid_ff <= 1'b0;
        end
    end
    assign rx_data = hold_ff;
    assign rx_valid = hold_valid_ff;

    // Held high from reset and while busy, so the port end pauses before its next byte
    always_ff @(posedge core_clk) begin
        if (rst) begin
            permit_n_ff <= 1'b1;
        end else begin
            permit_n_ff <= hold_valid_ff || rx_byte_valid || rx_busy;
        end
    end
    assign link.transmit_permit_n = permit_n_ff;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            peer_active_ff <= 1'b0;
            peer_overflow_ff <= 1'b0;
        end else begin
            peer_active_ff <= active_sync_ff[1];
            peer_overflow_ff <= !ovf_sync_ff[1];
        end
    end
    assign peer_active = peer_active_ff;
    assign peer_overflow = peer_overflow_ff;
endmodule : serial_partner_end

module uart_bit_tx #(
    parameter int BIT_CYCLES = uart_link_pkg::BIT_CYCLES
) (
    input wire logic core_clk,                            // Clock
    input wire logic rst,                                 // Synchronous reset
    input wire logic enable,                              // Transmitter allowed
    input wire logic permit_n,                            // Synchronised permit, low lets a byte start
    input wire logic [uart_link_pkg::DATA_BITS-1:0] data, // Byte to send
    input wire logic valid,                               // Byte offered
    output logic ready,                                   // Byte taken this cycle when valid
    output logic txd,                                     // Serial line
    output logic active                                   // Frame in progress
);
    localparam int CW = $clog2(BIT_CYCLES);
    localparam logic [CW-1:0] LAST_CYCLE = CW'(BIT_CYCLES - 1);
    localparam logic [2:0] LAST_BIT = 3'(uart_link_pkg::DATA_BITS - 1);
    uart_link_pkg::tx_state_t state_ff;
    logic [CW-1:0] cyc_ff;
    logic [2:0] bit_ff;
    logic [uart_link_pkg::DATA_BITS-1:0] shift_ff;
    logic txd_ff;
    logic tick;

    // Permit is only looked at between bytes; a byte already started always completes
    assign ready = state_ff == uart_link_pkg::TX_IDLE && enable && !permit_n;
    assign tick = cyc_ff == LAST_CYCLE;
    assign txd = txd_ff;
    assign active = state_ff != uart_link_pkg::TX_IDLE;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff <= uart_link_pkg::TX_IDLE;
        end else begin
            unique case (state_ff)
                uart_link_pkg::TX_IDLE: begin
                    if (valid && ready) begin
                        state_ff <= uart_link_pkg::TX_START;
                    end
                end
                uart_link_pkg::TX_START: begin
                    if (tick) begin
                        state_ff <= uart_link_pkg::TX_DATA;
                    end
                end
                uart_link_pkg::TX_DATA: begin
                    if (tick && bit_ff == LAST_BIT) begin
                        state_ff <= uart_link_pkg::TX_STOP;
                    end
                end
                uart_link_pkg::TX_STOP: begin
                    if (tick) begin
                        state_ff <= uart_link_pkg::TX_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || state_ff == uart_link_pkg::TX_IDLE || tick) begin
            cyc_ff <= '0;
        end else begin
            cyc_ff <= cyc_ff + CW'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            shift_ff <= '0;
            bit_ff <= '0;
            txd_ff <= uart_link_pkg::LINE_IDLE;
        end else if (state_ff == uart_link_pkg::TX_IDLE) begin
            txd_ff <= uart_link_pkg::LINE_IDLE;
            bit_ff <= '0;
            if (valid && ready) begin
                shift_ff <= data;
                txd_ff <= uart_link_pkg::START_LEVEL;
            end
        end else if (tick) begin
            if (state_ff == uart_link_pkg::TX_START) begin
                txd_ff <= shift_ff[0];
            end else if (state_ff == uart_link_pkg::TX_DATA) begin
                bit_ff <= bit_ff + 3'(1);
                txd_ff <= (bit_ff == LAST_BIT) ? uart_link_pkg::STOP_LEVEL : shift_ff[bit_ff + 3'(1)];
            end else begin
                txd_ff <= uart_link_pkg::LINE_IDLE;
            end
        end
    end
endmodule : uart_bit_tx

module uart_bit_rx #(
    parameter int BIT_CYCLES = uart_link_pkg::BIT_CYCLES
) (
    input wire logic core_clk,                            // Clock
    input wire logic rst,                                 // Synchronous reset
    input wire logic enable,                              // Receiver allowed
    input wire logic rxd,                                 // Synchronised serial line
    output logic [uart_link_pkg::DATA_BITS-1:0] data,     // Last byte shifted in, also kept when its stop bit is bad
    output logic valid,                                   // One-cycle pulse per good byte
    output logic busy                                     // Frame in progress
);
    localparam int CW = $clog2(BIT_CYCLES);
    localparam logic [CW-1:0] LAST_CYCLE = CW'(BIT_CYCLES - 1);
    localparam logic [CW-1:0] MID_CYCLE = CW'(BIT_CYCLES / 2);
    localparam logic [2:0] LAST_BIT = 3'(uart_link_pkg::DATA_BITS - 1);
    uart_link_pkg::rx_state_t state_ff;
    logic [CW-1:0] cyc_ff;
    logic [2:0] bit_ff;
    logic [uart_link_pkg::DATA_BITS-1:0] data_ff;
    logic valid_ff;
    logic at_mid;
    logic at_end;

    assign at_mid = state_ff == uart_link_pkg::RX_START && cyc_ff == MID_CYCLE;
    assign at_end = cyc_ff == LAST_CYCLE;
    assign data = data_ff;
    assign valid = valid_ff;
    assign busy = state_ff != uart_link_pkg::RX_IDLE;

    always_ff @(posedge core_clk) begin
        if (rst || !enable) begin
            state_ff <= uart_link_pkg::RX_IDLE;
        end else begin
            unique case (state_ff)
                uart_link_pkg::RX_IDLE: begin
                    if (rxd == uart_link_pkg::START_LEVEL) begin
                        state_ff <= uart_link_pkg::RX_START;
                    end
                end
                uart_link_pkg::RX_START: begin
                    // A glitch shorter than half a bit is not a start bit
                    if (at_mid) begin
                        state_ff <= (rxd == uart_link_pkg::START_LEVEL) ? uart_link_pkg::RX_DATA
                                                                       : uart_link_pkg::RX_IDLE;
                    end
                end
                uart_link_pkg::RX_DATA: begin
                    if (at_end && bit_ff == LAST_BIT) begin
                        state_ff <= uart_link_pkg::RX_STOP;
                    end
                end
                uart_link_pkg::RX_STOP: begin
                    if (at_end) begin
                        state_ff <= uart_link_pkg::RX_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || state_ff == uart_link_pkg::RX_IDLE || at_mid
                || (state_ff != uart_link_pkg::RX_START && at_end)) begin
            cyc_ff <= '0;
        end else begin
            cyc_ff <= cyc_ff + CW'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bit_ff <= '0;
            data_ff <= '0;
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= 1'b0;
            if (state_ff == uart_link_pkg::RX_START) begin
                bit_ff <= '0;
            end else if (state_ff == uart_link_pkg::RX_DATA && at_end) begin
                data_ff[bit_ff] <= rxd;
                bit_ff <= bit_ff + 3'(1);
            end else if (state_ff == uart_link_pkg::RX_STOP && at_end) begin
                // Framing errors are dropped silently
                valid_ff <= rxd == uart_link_pkg::STOP_LEVEL;
            end
        end
    end
endmodule : uart_bit_rx

// ==== verification/uart_link_asserts.sv ====
// Link checker between the port end and the partner end
`timescale 1ns/1ns
module uart_link_asserts #(
    parameter int BIT_CYCLES = uart_link_pkg::BIT_CYCLES
) (
    input wire logic core_clk, // Clock
    input wire logic rst, // Reset
    input wire logic serial_out, // To partner
    input wire logic serial_in, // From partner
    input wire logic transmit_permit_n, // Permit
    input wire logic ready_n, // Port ready
    input wire logic transmit_active, // Port sending
    input wire logic receive_overflow_n // Overflow
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [15:0] act_ff;
    always_ff @(posedge core_clk) begin
        act_ff <= (rst || !transmit_active) ? 16'h0000 : act_ff + 16'h0001;
    end
    // Start bit check needs BIT_CYCLES of 8 or more
    property p_idle; !transmit_active |-> serial_out; endproperty
    property p_start; $rose(transmit_active) |-> !serial_out [*8]; endproperty
    property p_stop; $fell(transmit_active) |-> $past(serial_out); endproperty
    property p_len; $fell(transmit_active) |-> int'(act_ff) == 10 * BIT_CYCLES; endproperty
    property p_hold; (!transmit_active && transmit_permit_n) [*4] |=> !transmit_active; endproperty
    property p_busy; $rose(transmit_active) |-> ##[1:8] transmit_permit_n; endproperty
    property p_rst; $fell(rst) |-> (ready_n && serial_out && serial_in && receive_overflow_n) [*8]; endproperty
    property p_ovf; $fell(receive_overflow_n) |-> ready_n; endproperty
    a_idle: assert property (p_idle) else $error("line low idle");
    a_start: assert property (p_start) else $error("short start");
    a_stop: assert property (p_stop) else $error("bad stop");
    a_len: assert property (p_len) else $error("bad frame length");
    a_hold: assert property (p_hold) else $error("sent while held");
    a_busy: assert property (p_busy) else $error("partner permit low");
    a_rst: assert property (p_rst) else $error("busy after reset");
    a_ovf: assert property (p_ovf) else $error("ready with overflow");
    cover property ($rose(transmit_active));
    cover property ($fell(receive_overflow_n));
    cover property ($rose(ready_n));
endmodule : uart_link_asserts

// ==== verification/tb.sv ====
// Bench: port end and partner end joined over the serial link
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %0t %h %h", $time, a, e); end end
module tb;
    logic core_clk = 1'b0, rst = 1'b1, tied = 1'b0, usb_cfg = 1'b1;
    logic [7:0] tx_d [2] = '{2{8'h00}};
    logic [7:0] rx_d [2];
    logic tx_v [2] = '{2{1'b0}};
    logic rx_r [2] = '{2{1'b0}};
    logic tx_r [2], rx_v [2];
    logic sda_out, sda_oe, serial_mode, printer_mode, peer_ovf, peer_act;
    int checks = 0, n_mismatch = 0;
    wire logic sda_pin = sda_oe ? sda_out : 1'b1;
    always #25 core_clk = ~core_clk;
    uart_link_if link();
    // Bit time of 8 keeps a frame at 80 cycles
    serial_port_end #(.BIT_CYCLES(8)) u_serial_port_end (.core_clk(core_clk), .rst(rst), .usb_configured(usb_cfg),
        .tx_data(tx_d[0]), .tx_valid(tx_v[0]), .tx_ready(tx_r[0]), .rx_data(rx_d[0]), .rx_valid(rx_v[0]),
        .rx_ready(rx_r[0]), .cfg_sda_in(sda_pin), .cfg_sda_out(sda_out), .cfg_sda_oe(sda_oe),
        .cfg_scl_in(tied ? sda_pin : 1'b1), .serial_mode(serial_mode), .printer_mode(printer_mode),
        .link(link.port_end));
    serial_partner_end #(.BIT_CYCLES(8)) u_serial_partner_end (.core_clk(core_clk), .rst(rst), .tx_data(tx_d[1]),
        .tx_valid(tx_v[1]), .tx_ready(tx_r[1]), .rx_data(rx_d[1]), .rx_valid(rx_v[1]), .rx_ready(rx_r[1]),
        .peer_active(peer_act), .peer_overflow(peer_ovf), .link(link.partner_end));
    uart_link_asserts #(.BIT_CYCLES(8)) u_chk (.core_clk(core_clk), .rst(rst), .serial_out(link.serial_out),
        .serial_in(link.serial_in), .transmit_permit_n(link.transmit_permit_n), .ready_n(link.ready_n),
        .transmit_active(link.transmit_active), .receive_overflow_n(link.receive_overflow_n));
    task automatic xfer(input int s, input logic [7:0] b);
        @(negedge core_clk);
        tx_d[s] = b;
        tx_v[s] = 1'b1;
        for (int i = 0; i < 4000 && tx_r[s] !== 1'b1; i++) @(negedge core_clk);
        `CHK(tx_r[s], 1'b1)
        @(negedge core_clk);
        tx_v[s] = 1'b0;
    endtask : xfer
    task automatic recv(input int s, input logic [7:0] e);
        @(negedge core_clk);
        for (int i = 0; i < 4000 && rx_v[s] !== 1'b1; i++) @(negedge core_clk);
        `CHK(rx_v[s], 1'b1)
        `CHK(rx_d[s], e)
        rx_r[s] = 1'b1;
        @(negedge core_clk);
        rx_r[s] = 1'b0;
    endtask : recv
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        final_report();
    end
    initial begin
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        repeat (25) @(negedge core_clk);
        `CHK({serial_mode, printer_mode}, 2'b10)
        xfer(0, 8'ha5);
        repeat (4) @(negedge core_clk);
        `CHK(peer_act, 1'b1)
        fork
            xfer(0, 8'h3c);
            begin
                repeat (200) @(negedge core_clk);
                `CHK(tx_r[0], 1'b0)
                `CHK(peer_act, 1'b0)
                recv(1, 8'ha5);
            end
        join
        recv(1, 8'h3c);
        $display("paced send done");
        fork
            for (int k = 0; k < 9; k++) xfer(1, 8'(k));
            begin
                repeat (1000) @(negedge core_clk);
                `CHK({peer_ovf, link.ready_n}, 2'b11)
                for (int k = 0; k < 9; k++) recv(0, 8'(k));
            end
        join
        repeat (5) @(negedge core_clk);
        `CHK({peer_ovf, link.ready_n}, 2'b00)
        usb_cfg = 1'b0;
        repeat (2) @(negedge core_clk);
        `CHK(link.ready_n, 1'b1)
        usb_cfg = 1'b1;
        repeat (2) @(negedge core_clk);
        `CHK(link.ready_n, 1'b0)
        $display("receive flow done");
        {tied, rst} = 2'b11;
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        repeat (25) @(negedge core_clk);
        tied = 1'b0;
        repeat (25) @(negedge core_clk);
        `CHK({serial_mode, printer_mode, link.ready_n}, 3'b011)
        $display("printer strap done");
        final_report();
    end
endmodule : tb
